// *** apsc_pkg.sv ***
// constants, types and state layout of the power and serial-format register group
// assumes a byte-wide register port fed by the control-bus target engine
// Function
// - rail select: external or on-chip regulator
// - reference charge code picks 3.5-100 ms
// - broadcast bit adds target address 1001100
// - awake bit low holds device asleep
// - input charge code picks 2.5-50 ms
// - format code: TDM, I2S, left-justified; 3 reserved
// - word width 16/20/24/32, resets to 32
// - polarity bits invert frame sync, bit clock
// - transmit-edge bit delays launch half cycle
// - unused cycles drive zero or float
package apsc_pkg;

  localparam logic [7:0] ADDR_SLEEP = 8'h02;
  localparam logic [7:0] ADDR_SHDN  = 8'h05;
  localparam logic [7:0] ADDR_FMT   = 8'h07;
  localparam logic [7:0] ADDR_SOUT  = 8'h08;

  localparam logic [7:0] RST_SLEEP = 8'h00;
  localparam logic [7:0] RST_SHDN  = 8'h05;
  localparam logic [7:0] RST_FMT   = 8'h30;
  localparam logic [7:0] RST_SOUT  = 8'h00;
  localparam logic [7:0] RD_ZERO   = 8'h00;

  // writable bits; read-only reserved bits stay zero
  localparam logic [7:0] SLEEP_WR_MASK = 8'hFD;
  localparam logic [7:0] SHDN_WR_MASK  = 8'h3F;

  localparam int SLP_RAIL_BIT  = 7;
  localparam int SLP_REF_LSB   = 3;
  localparam int SLP_BCAST_BIT = 2;
  localparam int SLP_AWAKE_BIT = 0;
  localparam int SHDN_INCAP_LSB = 4;
  localparam int FMT_PROTO_LSB = 6;
  localparam int FMT_WLEN_LSB  = 4;
  localparam int FMT_FRAME_SYNC_BIT = 3;
  localparam int FMT_BCLK_BIT  = 2;
  localparam int FMT_EDGE_BIT  = 1;
  localparam int FMT_FILL_BIT  = 0;

  localparam logic [6:0] BCAST_ADDR = 7'h4C;

  localparam int CLK_MHZ = 40;
  localparam int REF_TIME_US [4]   = '{3500, 10000, 50000, 100000};
  localparam int INCAP_TIME_US [4] = '{2500, 12500, 25000, 50000};
  localparam int CNT_W = 23;

  localparam logic [5:0] WORD_BITS [4] = '{6'h10, 6'h14, 6'h18, 6'h20};

  localparam int LANES = 2;

  typedef enum logic [1:0] {APSC_TDM, APSC_I2S, APSC_LJ, APSC_RSVD} apsc_proto_e;

  typedef struct packed {
    logic [7:0]       sleep_cfg;
    logic [7:0]       shutdown_config;
    logic [7:0]       fmt_cfg;
    logic [7:0]       sout_cfg;
    logic [7:0]       rdata;
    logic [CNT_W-1:0] ref_cnt;
    logic [CNT_W-1:0] incap_cnt;
    logic [LANES-1:0] sd;
    logic [LANES-1:0] sd_oe;
  } apsc_state_s;

endpackage

// *** apsc_top.sv ***
// power, sleep and serial-format register group with quick-charge timers
// assumes the control-bus engine hands over decoded byte accesses and address bytes
`timescale 1ns/1ps
module apsc_top #(
  parameter int REF_CYC [4] = '{apsc_pkg::REF_TIME_US[0] * apsc_pkg::CLK_MHZ,
                                apsc_pkg::REF_TIME_US[1] * apsc_pkg::CLK_MHZ,
                                apsc_pkg::REF_TIME_US[2] * apsc_pkg::CLK_MHZ,
                                apsc_pkg::REF_TIME_US[3] * apsc_pkg::CLK_MHZ},
  parameter int INCAP_CYC [4] = '{apsc_pkg::INCAP_TIME_US[0] * apsc_pkg::CLK_MHZ,
                                  apsc_pkg::INCAP_TIME_US[1] * apsc_pkg::CLK_MHZ,
                                  apsc_pkg::INCAP_TIME_US[2] * apsc_pkg::CLK_MHZ,
                                  apsc_pkg::INCAP_TIME_US[3] * apsc_pkg::CLK_MHZ}
) (
  input  wire logic                       clk_i,
  input  wire logic                       srst_i,
  input  wire logic [7:0]                 reg_addr_i,
  input  wire logic [7:0]                 reg_wdata_i,
  input  wire logic                       reg_wr_i,
  input  wire logic                       reg_rd_i,
  output logic      [7:0]                 reg_rdata_o,
  input  wire logic [6:0]                 bus_addr_i,
  input  wire logic                       bus_addr_valid_i,
  input  wire logic [6:0]                 own_addr_i,
  output logic                            addr_match_o,
  output logic                            analog_rail_source_sel_o,
  output logic                            sleep_o,
  output logic                            ref_charge_active_o,
  output logic                            input_cap_charge_active_o,
  output apsc_pkg::apsc_proto_e           serial_protocol_sel_o,
  output logic      [5:0]                 serial_word_width_o,
  output logic                            frame_sync_invert_o,
  output logic                            bit_clock_invert_o,
  output logic                            launch_edge_invert_o,
  output logic      [7:0]                 serial_output_cfg_o,
  input  wire logic [apsc_pkg::LANES-1:0] sd_data_i,
  input  wire logic [apsc_pkg::LANES-1:0] sd_slot_used_i,
  output logic      [apsc_pkg::LANES-1:0] sd_o,
  output logic      [apsc_pkg::LANES-1:0] sd_oe_o
);

  apsc_pkg::apsc_state_s st_reg;
  apsc_pkg::apsc_state_s st_next;
  logic                  wake;
  logic [1:0]            ref_code;
  logic [1:0]            incap_code;

  always_comb
  begin
    st_next = st_reg;
    if (reg_wr_i)
    begin
      case (reg_addr_i)
        apsc_pkg::ADDR_SLEEP: st_next.sleep_cfg = reg_wdata_i & apsc_pkg::SLEEP_WR_MASK;
        apsc_pkg::ADDR_SHDN:  st_next.shutdown_config  = reg_wdata_i & apsc_pkg::SHDN_WR_MASK;
        apsc_pkg::ADDR_FMT:   st_next.fmt_cfg   = reg_wdata_i;
        apsc_pkg::ADDR_SOUT:  st_next.sout_cfg  = reg_wdata_i;
        default:              st_next.sout_cfg  = st_reg.sout_cfg;
      endcase
    end
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        apsc_pkg::ADDR_SLEEP: st_next.rdata = st_reg.sleep_cfg;
        apsc_pkg::ADDR_SHDN:  st_next.rdata = st_reg.shutdown_config;
        apsc_pkg::ADDR_FMT:   st_next.rdata = st_reg.fmt_cfg;
        apsc_pkg::ADDR_SOUT:  st_next.rdata = st_reg.sout_cfg;
        default:              st_next.rdata = apsc_pkg::RD_ZERO;
      endcase
    end
    // charge timers start when the device leaves sleep
    wake = st_next.sleep_cfg[apsc_pkg::SLP_AWAKE_BIT] & ~st_reg.sleep_cfg[apsc_pkg::SLP_AWAKE_BIT];
    ref_code   = st_reg.sleep_cfg[apsc_pkg::SLP_REF_LSB +: 2];
    incap_code = st_reg.shutdown_config[apsc_pkg::SHDN_INCAP_LSB +: 2];
    if (wake)
    begin
      st_next.ref_cnt   = apsc_pkg::CNT_W'(REF_CYC[ref_code]);
      st_next.incap_cnt = apsc_pkg::CNT_W'(INCAP_CYC[incap_code]);
    end
    else
    begin
      if (st_reg.ref_cnt != '0)
        st_next.ref_cnt = st_reg.ref_cnt - 1'b1;
      if (st_reg.incap_cnt != '0)
        st_next.incap_cnt = st_reg.incap_cnt - 1'b1;
    end
    // going back to sleep aborts any charge in progress
    if (!st_next.sleep_cfg[apsc_pkg::SLP_AWAKE_BIT])
    begin
      st_next.ref_cnt   = '0;
      st_next.incap_cnt = '0;
    end
    for (int i = 0; i < apsc_pkg::LANES; i++)
    begin
      if (sd_slot_used_i[i])
      begin
        st_next.sd[i]    = sd_data_i[i];
        st_next.sd_oe[i] = 1'b1;
      end
      else
      begin
        st_next.sd[i]    = 1'b0;
        st_next.sd_oe[i] = ~st_reg.fmt_cfg[apsc_pkg::FMT_FILL_BIT];
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      st_reg           <= '0;
      st_reg.sleep_cfg <= apsc_pkg::RST_SLEEP;
      st_reg.shutdown_config  <= apsc_pkg::RST_SHDN;
      st_reg.fmt_cfg   <= apsc_pkg::RST_FMT;
      st_reg.sout_cfg  <= apsc_pkg::RST_SOUT;
    end
    else
      st_reg <= st_next;
  end

  always_comb
  begin
    case (st_reg.fmt_cfg[apsc_pkg::FMT_PROTO_LSB +: 2])
      2'h0:    serial_protocol_sel_o = apsc_pkg::APSC_TDM;
      2'h1:    serial_protocol_sel_o = apsc_pkg::APSC_I2S;
      2'h2:    serial_protocol_sel_o = apsc_pkg::APSC_LJ;
      default: serial_protocol_sel_o = apsc_pkg::APSC_RSVD;
    endcase
  end

  // a broadcast match only widens the set of accepted addresses
  assign addr_match_o = bus_addr_valid_i & ((bus_addr_i == own_addr_i) |
                        (st_reg.sleep_cfg[apsc_pkg::SLP_BCAST_BIT] &
                         (bus_addr_i == apsc_pkg::BCAST_ADDR)));

  assign reg_rdata_o               = st_reg.rdata;
  assign analog_rail_source_sel_o  = st_reg.sleep_cfg[apsc_pkg::SLP_RAIL_BIT];
  assign sleep_o                   = ~st_reg.sleep_cfg[apsc_pkg::SLP_AWAKE_BIT];
  assign ref_charge_active_o       = st_reg.ref_cnt != '0;
  assign input_cap_charge_active_o = st_reg.incap_cnt != '0;
  assign serial_word_width_o       = apsc_pkg::WORD_BITS[st_reg.fmt_cfg[apsc_pkg::FMT_WLEN_LSB +: 2]];
  assign frame_sync_invert_o       = st_reg.fmt_cfg[apsc_pkg::FMT_FRAME_SYNC_BIT];
  assign bit_clock_invert_o        = st_reg.fmt_cfg[apsc_pkg::FMT_BCLK_BIT];
  assign launch_edge_invert_o      = st_reg.fmt_cfg[apsc_pkg::FMT_BCLK_BIT] ^
                                     st_reg.fmt_cfg[apsc_pkg::FMT_EDGE_BIT];
  assign serial_output_cfg_o       = st_reg.sout_cfg;
  assign sd_o                      = st_reg.sd;
  assign sd_oe_o                   = st_reg.sd_oe;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  sequence sleep_wr_s;
    reg_wr_i && reg_addr_i == apsc_pkg::ADDR_SLEEP;
  endsequence
  sequence fmt_wr_s;
    reg_wr_i && reg_addr_i == apsc_pkg::ADDR_FMT;
  endsequence

  rail_select_a: assert property (sleep_wr_s |=>
    analog_rail_source_sel_o == $past(reg_wdata_i[apsc_pkg::SLP_RAIL_BIT]))
    else $error("rail select does not follow write");
  ref_charge_a: assert property (wake && !$past(wake) |=>
    st_reg.ref_cnt == apsc_pkg::CNT_W'(REF_CYC[$past(ref_code)]) && ref_charge_active_o)
    else $error("reference charge time not loaded");
  bcast_match_a: assert property (bus_addr_valid_i && bus_addr_i == apsc_pkg::BCAST_ADDR &&
    own_addr_i != apsc_pkg::BCAST_ADDR |->
    addr_match_o == st_reg.sleep_cfg[apsc_pkg::SLP_BCAST_BIT])
    else $error("broadcast address match wrong");
  sleep_hold_a: assert property (sleep_wr_s ##0 !reg_wdata_i[apsc_pkg::SLP_AWAKE_BIT] |=>
    sleep_o && !ref_charge_active_o && !input_cap_charge_active_o)
    else $error("sleep not entered");
  incap_charge_a: assert property (wake |=>
    st_reg.incap_cnt == apsc_pkg::CNT_W'(INCAP_CYC[$past(incap_code)]))
    else $error("input charge time not loaded");
  proto_sel_a: assert property (fmt_wr_s ##0 reg_wdata_i[7:6] == 2'h1 |=>
    serial_protocol_sel_o == apsc_pkg::APSC_I2S)
    else $error("protocol decode wrong");
  word_width_a: assert property (fmt_wr_s ##0 reg_wdata_i[5:4] == 2'h0 |=>
    serial_word_width_o == 6'h10 ##1 (serial_word_width_o == 6'h10 ||
    $past(reg_wr_i && reg_addr_i == apsc_pkg::ADDR_FMT)))
    else $error("word width decode wrong");
  polarity_a: assert property (fmt_wr_s |=>
    frame_sync_invert_o == $past(reg_wdata_i[3]) && bit_clock_invert_o == $past(reg_wdata_i[2]))
    else $error("polarity bits not applied");
  launch_edge_a: assert property (fmt_wr_s |=>
    launch_edge_invert_o == ($past(reg_wdata_i[2]) ^ $past(reg_wdata_i[1])))
    else $error("launch edge wrong");
  fill_float_a: assert property (!sd_slot_used_i[0] |=>
    !sd_o[0] && sd_oe_o[0] == !$past(st_reg.fmt_cfg[apsc_pkg::FMT_FILL_BIT]))
    else $error("unused cycle fill wrong");

endmodule

// *** apsc_host.sv ***
// host model: drives the byte-wide register port of the power and format group
// assumes read data is valid one cycle after the read strobe
`timescale 1ns/1ps
module apsc_host (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o,
  output logic            wr_o,
  output logic            rd_o
);
  initial
  begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // entered just after a rising edge; data inverted once released
  // one idle edge first so a strobe never rises in the step where it fell
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(posedge clk_i);
    #1;
    wr_o = 1'b0;
    wdata_o = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    rd_o = 1'b1;
    @(posedge clk_i);
    #1;
    rd_o = 1'b0;
    d = rdata_i;
  endtask
  // serial setup done asleep, reserved format code never issued
  task automatic cfg_fmt(input logic [7:0] slp, input logic [7:0] fmt);
    wr(8'h02, slp & 8'hFE);
    if (fmt[7:6] != 2'b11)
      wr(8'h07, fmt);
    wr(8'h02, slp);
  endtask
endmodule

// *** apsc_top_bench.sv ***
// self-checking bench for the power, sleep and serial-format register group
// assumes short quick-charge counts so wake timing runs in a few cycles
`timescale 1ns/1ps
module apsc_top_bench;
  logic clk_i = 1'b0, srst_i = 1'b1, bav = 1'b0;
  logic [6:0] bad = 7'h00;
  logic [7:0] rdata, rv, a, w;
  logic [1:0] sdd = 2'b00, used = 2'b00, sd, oe;
  logic rail, slp, refa, inca, match, fsi, bci, lei;
  logic [5:0] wid;
  logic [7:0] sout;
  apsc_pkg::apsc_proto_e proto;
  int n_errors = 0, n_tests = 0, cnt;
  logic wr, rd;
  logic [7:0] rst_a [5] = '{8'h02, 8'h05, 8'h07, 8'h08, 8'h03};
  logic [7:0] rst_v [5] = '{8'h00, 8'h05, 8'h30, 8'h00, 8'h00};
  apsc_host i_apsc_host (.clk_i(clk_i), .rdata_i(rdata), .addr_o(a), .wdata_o(w),
    .wr_o(wr), .rd_o(rd));
  apsc_top #(.REF_CYC('{10, 20, 30, 40}), .INCAP_CYC('{5, 15, 25, 35})) i_apsc_top (
    .clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(a), .reg_wdata_i(w), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .bus_addr_i(bad), .bus_addr_valid_i(bav),
    .own_addr_i(7'h10), .addr_match_o(match), .analog_rail_source_sel_o(rail),
    .sleep_o(slp), .ref_charge_active_o(refa), .input_cap_charge_active_o(inca),
    .serial_protocol_sel_o(proto), .serial_word_width_o(wid), .frame_sync_invert_o(fsi),
    .bit_clock_invert_o(bci), .launch_edge_invert_o(lei), .serial_output_cfg_o(sout),
    .sd_data_i(sdd), .sd_slot_used_i(used), .sd_o(sd), .sd_oe_o(oe));
  initial
  begin
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic step;
    @(posedge clk_i);
    #1;
  endtask
  initial
  begin
    repeat (10) @(posedge clk_i);
    #1 srst_i = 1'b0;
    foreach (rst_a[i])
    begin
      i_apsc_host.rd(rst_a[i], rv);
      chk("reset read", rst_v[i], rv);
    end
    chk("sleep at reset", 8'h01, {7'h00, slp});
    $display("test reset done");
    for (int c = 0; c < 3; c++)
    begin
      i_apsc_host.cfg_fmt(8'h00, {c[1:0], c[1:0], 4'h0});
      chk("protocol", 8'(c), proto);
      chk("width", 8'(8'h10 + 8'h04 * c), wid);
    end
    i_apsc_host.cfg_fmt(8'h00, 8'h3C);
    chk("frame_sync inv", 8'h01, fsi);
    chk("bclk inv", 8'h01, bci);
    chk("width", 8'h20, wid);
    // launch flag is relative to the standard edge: clock invert xor transmit edge
    chk("edge", 8'h01, lei);
    i_apsc_host.wr(8'h07, 8'h3E);
    chk("edge late", 8'h00, lei);
    i_apsc_host.wr(8'h07, 8'h32);
    chk("edge std late", 8'h01, lei);
    $display("test format done");
    bad = 7'h4C;
    bav = 1'b1;
    step();
    chk("no bcast", 8'h00, match);
    i_apsc_host.wr(8'h02, 8'h84);
    chk("bcast", 8'h01, match);
    chk("rail", 8'h01, rail);
    $display("test bcast done");
    // codes held before the waking write set the counts
    i_apsc_host.wr(8'h05, 8'h15);
    i_apsc_host.wr(8'h02, 8'h08);
    i_apsc_host.wr(8'h02, 8'h09);
    chk("awake", 8'h00, slp);
    cnt = 0;
    while (inca && cnt < 100)
    begin
      cnt++;
      step();
    end
    chk("incap cycles", 8'h0F, cnt[7:0]);
    while (refa && cnt < 100)
    begin
      cnt++;
      step();
    end
    chk("ref cycles", 8'h14, cnt[7:0]);
    i_apsc_host.rd(8'h02, rv);
    chk("sleep reg", 8'h09, rv);
    $display("test charge done");
    sdd = 2'b10;
    used = 2'b11;
    step();
    step();
    chk("used lanes", 8'h0B, {4'h0, sd, oe});
    used = 2'b00;
    step();
    step();
    chk("fill zero", 8'h03, {4'h0, sd, oe});
    i_apsc_host.cfg_fmt(8'h09, 8'h01);
    chk("width", 8'h10, wid);
    step();
    chk("fill hiz", 8'h00, {4'h0, sd, oe});
    $display("test lanes done");
    summarize();
  end
endmodule
